// ==== logic/irc_pkg.sv ====
package irc_pkg;

    //--------------------------------------------------------------
    // Clock rates and derived divider
    //--------------------------------------------------------------
    localparam int MCLK_HZ = 50_000_000;
    localparam int LOW_SPEED_OSC_FREQ_HZ = 32_768;
    localparam int OSC_DIV = MCLK_HZ / LOW_SPEED_OSC_FREQ_HZ;

    //--------------------------------------------------------------
    // Timing in low-speed oscillator periods
    //--------------------------------------------------------------
    localparam int QUAL_TIME_S = 2;
    localparam int QUAL_STEP_TICKS = LOW_SPEED_OSC_FREQ_HZ * QUAL_TIME_S / 2;
    localparam int STAB_TICKS = 8192;
    localparam int PULSE_TICKS = 64;
    localparam int TMR_W = 16;

    //--------------------------------------------------------------
    // Reset values and addresses
    //--------------------------------------------------------------
    localparam logic [23:0] VEC_ADDR_LO = 24'h000000;
    localparam logic [23:0] VEC_ADDR_HI = 24'h000001;
    localparam logic [23:0] SYS_CFG0_ADDR = 24'h00ff00;
    localparam logic [23:0] SYS_CFG1_ADDR = 24'h00ff01;
    localparam logic [7:0] NEW_CODE_BANK_RST = 8'h01;
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [7:0] STACK_PAGE = 8'h00;
    localparam logic [1:0] BUS_SINGLE_CHIP = 2'h0;
    localparam int BUS_MODE_MSB = 7;
    localparam int BUS_MODE_LSB = 6;

    //--------------------------------------------------------------
    // Key reset group selection
    //--------------------------------------------------------------
    localparam logic [1:0] KEY_SEL_OFF = 2'h0;
    localparam logic [1:0] KEY_SEL_TWO = 2'h1;
    localparam logic [1:0] KEY_SEL_THREE = 2'h2;
    localparam logic [1:0] KEY_SEL_FOUR = 2'h3;

    typedef enum logic [2:0] {
        ST_HOLD,
        ST_PULSE,
        ST_STAB,
        ST_VEC_LO,
        ST_VEC_HI,
        ST_RUN
    } irc_state_e;

    // CPU state given by reset
    typedef struct packed {
        logic zero;
        logic carry;
        logic overflow;
        logic negative;
        logic decimal;
        logic unpack;
        logic interrupt_mask_flag_low;
        logic interrupt_mask_flag_high;
        logic [7:0] new_code_bank_reg;
        logic [7:0] code_bank_reg;
        logic [7:0] expand_page_reg;
        logic [7:0] first_index_page_reg;
        logic [7:0] second_index_page_reg;
        logic [15:0] pc;
    } irc_cpu_s;

    // Whole state of the controller
    typedef struct packed {
        irc_state_e state;
        logic [TMR_W-1:0] tmr;
        logic [TMR_W-1:0] sec_cnt;
        logic key_secs;
        logic key_hold;
        logic [1:0] cfg_seen;
        irc_cpu_s cpu;
        logic [1:0] bus_mode;
        logic pin_func;
        logic vec_rd;
        logic [23:0] vec_addr;
        logic cpu_rst;
        logic periph_rst;
        logic cpu_run;
        logic int_mask;
        logic [7:0] stack_page;
    } irc_regs_s;

    // True when every key of the selected group is low
    function automatic logic key_group_low(input logic [1:0] sel,
                                           input logic [3:0] keys);
        logic r;
        r = 1'b0;
        case (sel)
            KEY_SEL_TWO: r = ~|keys[1:0];
            KEY_SEL_THREE: r = ~|keys[2:0];
            KEY_SEL_FOUR: r = ~|keys[3:0];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

endpackage

// ==== logic/irc_osc_sampler.sv ====
`timescale 1ns/1ps
`default_nettype none

module irc_osc_sampler #(
    parameter int DIV = irc_pkg::OSC_DIV
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic [3:0] i_key_reset_inputs,
    input wire logic i_reset_pin_b,
    output logic o_tick,
    output logic [3:0] o_key_s,
    output logic o_reset_pin_b_s
);

    //--------------------------------------------------------------
    // Divider and two-stage samplers on the low-speed rate
    //--------------------------------------------------------------
    typedef struct packed {
        logic [15:0] div;
        logic tick;
        logic [3:0] key_m;
        logic [3:0] key_s;
        logic pin_m;
        logic pin_s;
    } irc_smp_s;

    irc_smp_s q;
    irc_smp_s d;

    if (DIV < 2 || DIV > 65535) begin : g_chk
        $error("Divider out of range");
    end

    // First stage only feeds second stage
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.div == 16'(DIV - 1)) begin
            d.div = 16'h0000;
            d.tick = 1'b1;
            d.key_m = i_key_reset_inputs;
            d.key_s = q.key_m;
            d.pin_m = i_reset_pin_b;
            d.pin_s = q.pin_m;
        end else begin
            d.div = q.div + 16'h0001;
        end
    end

    // Pin starts seen as asserted so power-on holds reset
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            q <= '{16'h0000, 1'b0, 4'hf, 4'hf, 1'b0, 1'b0};
        end else begin
            q <= d;
        end
    end

    assign o_tick = q.tick;
    assign o_key_s = q.key_s;
    assign o_reset_pin_b_s = q.pin_s;

endmodule

`default_nettype wire

// ==== logic/irc_initial_reset_controller.sv ====
// Functional notes
// - Reset comes from the reset pin or the selected key group all low.
// - CPU and peripherals held while a source is active; then vector fetch.
// - Start vector read from addresses 000000H-000001H into PC.
// - Code bank register takes new code bank value during vector fetch.
// - Key reset in normal run needs inputs low one to two seconds.
// - In sleep or stabilisation wait the key group resets at once.
// - Key group option: off, two, three or four inputs.
// - After pin release CPU waits 8192 low-speed periods.
// - Key reset from sleep: start after release plus stabilisation wait.
// - Qualified key reset fires in 1-2 s, gives a 64-period pulse.
// - Reset clears six ALU flags and sets both interrupt mask flags.
// - Reset clears expand page and both index page registers.
// - Reset sets new code bank register to 01H.
// - Stack page is always page 0.
// - Reset leaves internal RAM untouched.
// - Bus mode resets to single chip, or option mode with external ROM.
// - Shared pins reset to plain port functions.
// - All interrupts masked until both system config locations written.
`timescale 1ns/1ps
`default_nettype none

module irc_initial_reset_controller #(
    parameter int OSC_DIV = irc_pkg::OSC_DIV,
    parameter int STAB_TICKS = irc_pkg::STAB_TICKS,
    parameter int QUAL_STEP_TICKS = irc_pkg::QUAL_STEP_TICKS,
    parameter int PULSE_TICKS = irc_pkg::PULSE_TICKS
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_reset_pin_b,
    input wire logic [3:0] i_key_reset_inputs,
    input wire logic [1:0] i_key_sel,
    input wire logic i_sleep,
    input wire logic i_external_rom_mode,
    input wire logic [1:0] i_bus_mode_opt,
    input wire logic [7:0] i_vec_data,
    input wire logic i_cfg_wr,
    input wire logic [23:0] i_cfg_addr,
    input wire logic [7:0] i_cfg_data,
    input wire logic i_pin_func_set,
    output logic o_vec_rd,
    output logic [23:0] o_vec_addr,
    output logic o_cpu_rst,
    output logic o_periph_rst,
    output logic o_cpu_run,
    output logic o_int_mask,
    output irc_pkg::irc_cpu_s o_cpu,
    output logic [1:0] o_bus_mode,
    output logic o_pin_func,
    output logic [7:0] o_stack_page
);

    //--------------------------------------------------------------
    // Parameter checks
    //--------------------------------------------------------------
    if (STAB_TICKS < 2 || STAB_TICKS > 65535 ||
        QUAL_STEP_TICKS < 2 || QUAL_STEP_TICKS > 65535 ||
        PULSE_TICKS < 2 || PULSE_TICKS > 65535) begin : g_chk
        $error("Tick counts out of range");
    end

    localparam logic [15:0] STAB_LAST = 16'(STAB_TICKS - 1);
    localparam logic [15:0] QUAL_LAST = 16'(QUAL_STEP_TICKS - 1);
    localparam logic [15:0] PULSE_LAST = 16'(PULSE_TICKS - 1);

    //--------------------------------------------------------------
    // Sampled inputs
    //--------------------------------------------------------------
    logic tick;
    logic [3:0] key_s;
    logic pin_b_s;
    logic key_act;

    irc_osc_sampler #(
        .DIV(OSC_DIV)
    ) u_sampler (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_key_reset_inputs(i_key_reset_inputs),
        .i_reset_pin_b(i_reset_pin_b),
        .o_tick(tick),
        .o_key_s(key_s),
        .o_reset_pin_b_s(pin_b_s)
    );

    // Selected key group all low
    assign key_act = irc_pkg::key_group_low(i_key_sel, key_s);

    //--------------------------------------------------------------
    // State
    //--------------------------------------------------------------
    irc_pkg::irc_regs_s q;
    irc_pkg::irc_regs_s d;
    logic sec_pulse;
    logic key_qual;
    logic key_now;

    // Reset image of the whole state
    localparam irc_pkg::irc_regs_s REGS_RST = '{
        state: irc_pkg::ST_HOLD,
        tmr: '0,
        sec_cnt: '0,
        key_secs: 1'b0,
        key_hold: 1'b0,
        cfg_seen: 2'h0,
        cpu: '0,
        bus_mode: irc_pkg::BUS_SINGLE_CHIP,
        pin_func: 1'b0,
        vec_rd: 1'b0,
        vec_addr: irc_pkg::VEC_ADDR_LO,
        cpu_rst: 1'b1,
        periph_rst: 1'b1,
        cpu_run: 1'b0,
        int_mask: 1'b1,
        stack_page: irc_pkg::STACK_PAGE
    };

    //--------------------------------------------------------------
    // Next-state logic
    //--------------------------------------------------------------
    always_comb begin
        d = q;
        d.vec_rd = 1'b0;
        sec_pulse = 1'b0;
        key_qual = 1'b0;

        // Unqualified key trigger, blocked after a pulse until release
        key_now = key_act && !q.key_hold;
        if (!key_act) begin
            d.key_hold = 1'b0;
        end

        // Free-running one-second steps give the 1-2 s window
        if (tick) begin
            if (q.sec_cnt == QUAL_LAST) begin
                d.sec_cnt = '0;
                sec_pulse = 1'b1;
            end else begin
                d.sec_cnt = q.sec_cnt + 16'h0001;
            end
        end

        // Second step boundary with keys still low qualifies
        if (!key_now || q.state != irc_pkg::ST_RUN) begin
            d.key_secs = 1'b0;
        end else if (sec_pulse) begin
            d.key_secs = 1'b1;
            key_qual = q.key_secs;
        end

        case (q.state)
            irc_pkg::ST_HOLD: begin
                // Leave when pin and key group are both released
                if (pin_b_s && !key_now) begin
                    d.state = irc_pkg::ST_STAB;
                    d.tmr = '0;
                end
            end
            irc_pkg::ST_PULSE: begin
                // Fixed-length internal pulse, keys may stay low
                if (tick) begin
                    if (q.tmr == PULSE_LAST) begin
                        d.state = irc_pkg::ST_STAB;
                        d.tmr = '0;
                        d.key_hold = 1'b1;
                    end else begin
                        d.tmr = q.tmr + 16'h0001;
                    end
                end
            end
            irc_pkg::ST_STAB: begin
                if (key_now) begin
                    d.state = irc_pkg::ST_HOLD;
                end else if (tick) begin
                    if (q.tmr == STAB_LAST) begin
                        d.state = irc_pkg::ST_VEC_LO;
                        d.vec_rd = 1'b1;
                        d.vec_addr = irc_pkg::VEC_ADDR_LO;
                    end else begin
                        d.tmr = q.tmr + 16'h0001;
                    end
                end
            end
            irc_pkg::ST_VEC_LO: begin
                // Low byte is captured in the same cycle as the read strobe
                d.cpu.pc[7:0] = i_vec_data;
                d.vec_rd = 1'b1;
                d.vec_addr = irc_pkg::VEC_ADDR_HI;
                d.state = irc_pkg::ST_VEC_HI;
            end
            irc_pkg::ST_VEC_HI: begin
                d.cpu.pc[15:8] = i_vec_data;
                d.cpu.code_bank_reg = q.cpu.new_code_bank_reg;
                d.state = irc_pkg::ST_RUN;
            end
            irc_pkg::ST_RUN: begin
                if (i_sleep && key_now) begin
                    d.state = irc_pkg::ST_HOLD;
                end else if (key_qual) begin
                    d.state = irc_pkg::ST_PULSE;
                    d.tmr = '0;
                end
            end
            default: begin
                d.state = irc_pkg::ST_HOLD;
            end
        endcase

        // The reset pin overrides every state
        if (!pin_b_s) begin
            d.state = irc_pkg::ST_HOLD;
        end

        // System configuration writes lift the interrupt mask
        if (q.state == irc_pkg::ST_RUN && i_cfg_wr) begin
            if (i_cfg_addr == irc_pkg::SYS_CFG0_ADDR) begin
                d.cfg_seen[0] = 1'b1;
                d.bus_mode = i_cfg_data[irc_pkg::BUS_MODE_MSB:
                                        irc_pkg::BUS_MODE_LSB];
            end
            if (i_cfg_addr == irc_pkg::SYS_CFG1_ADDR) begin
                d.cfg_seen[1] = 1'b1;
            end
        end
        if (q.state == irc_pkg::ST_RUN && i_pin_func_set) begin
            d.pin_func = 1'b1;
        end

        // Initial values while reset is applied; RAM is never touched
        if (d.state == irc_pkg::ST_HOLD || d.state == irc_pkg::ST_PULSE) begin
            d.cpu.zero = 1'b0;
            d.cpu.carry = 1'b0;
            d.cpu.overflow = 1'b0;
            d.cpu.negative = 1'b0;
            d.cpu.decimal = 1'b0;
            d.cpu.unpack = 1'b0;
            d.cpu.interrupt_mask_flag_low = 1'b1;
            d.cpu.interrupt_mask_flag_high = 1'b1;
            d.cpu.expand_page_reg = irc_pkg::PAGE_RST;
            d.cpu.first_index_page_reg = irc_pkg::PAGE_RST;
            d.cpu.second_index_page_reg = irc_pkg::PAGE_RST;
            d.cpu.new_code_bank_reg = irc_pkg::NEW_CODE_BANK_RST;
            d.bus_mode = i_external_rom_mode ? i_bus_mode_opt
                                             : irc_pkg::BUS_SINGLE_CHIP;
            d.pin_func = 1'b0;
            d.cfg_seen = 2'h0;
        end

        // Stack accesses always go to page 0
        d.stack_page = irc_pkg::STACK_PAGE;
        d.int_mask = ~&d.cfg_seen;

        // Registered reset and run outputs
        d.cpu_rst = (d.state != irc_pkg::ST_RUN);
        d.periph_rst = (d.state == irc_pkg::ST_HOLD ||
                        d.state == irc_pkg::ST_PULSE);
        d.cpu_run = (d.state == irc_pkg::ST_RUN);
    end

    //--------------------------------------------------------------
    // State register
    //--------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            q <= REGS_RST;
        end else begin
            q <= d;
        end
    end

    //--------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------
    assign o_vec_rd = q.vec_rd;
    assign o_vec_addr = q.vec_addr;
    assign o_cpu_rst = q.cpu_rst;
    assign o_periph_rst = q.periph_rst;
    assign o_cpu_run = q.cpu_run;
    assign o_int_mask = q.int_mask;
    assign o_cpu = q.cpu;
    assign o_bus_mode = q.bus_mode;
    assign o_pin_func = q.pin_func;
    assign o_stack_page = q.stack_page;

endmodule

`default_nettype wire

// ==== tb/irc_initial_reset_controller_sva.sv ====
`timescale 1ns/1ps
`default_nettype none

module irc_initial_reset_controller_sva #(
    parameter int OSC_DIV = irc_pkg::OSC_DIV,
    parameter int STAB_TICKS = irc_pkg::STAB_TICKS,
    parameter int PULSE_TICKS = irc_pkg::PULSE_TICKS
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_reset_pin_b,
    input wire logic i_sleep,
    input wire logic i_external_rom_mode,
    input wire logic [1:0] i_bus_mode_opt,
    input wire logic o_vec_rd,
    input wire logic [23:0] o_vec_addr,
    input wire logic o_cpu_rst,
    input wire logic o_periph_rst,
    input wire logic o_cpu_run,
    input wire logic o_int_mask,
    input wire irc_pkg::irc_cpu_s o_cpu,
    input wire logic [1:0] o_bus_mode,
    input wire logic o_pin_func,
    input wire logic [7:0] o_stack_page
);
    int hi_cnt;
    int lo_cnt;
    logic ext_q;

    // Cycles of hold, source of hold, and quiet wait before fetch
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            hi_cnt <= 0;
            lo_cnt <= 0;
            ext_q <= 1'b0;
        end else if (o_periph_rst) begin
            hi_cnt <= hi_cnt + 1;
            lo_cnt <= 0;
            ext_q <= ext_q | ~i_reset_pin_b | i_sleep;
        end else begin
            hi_cnt <= 0;
            ext_q <= !o_cpu_run;
            lo_cnt <= lo_cnt + int'(o_cpu_rst && !o_vec_rd);
        end
    end

    default clocking cb_m @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    sequence s_fetch;
        (o_vec_rd && o_vec_addr == 24'h000000)
        ##1 (o_vec_rd && o_vec_addr == 24'h000001) ##1 !o_vec_rd;
    endsequence
    property p_stack_pg;
        o_stack_page == 8'h00;
    endproperty
    property p_hold;
        o_periph_rst |-> o_cpu_rst && !o_cpu_run;
    endproperty
    property p_fetch;
        $rose(o_vec_rd) |-> s_fetch ##1 (o_cpu_run && !o_cpu_rst);
    endproperty
    property p_reg_vals;
        o_vec_rd |-> {o_cpu.zero, o_cpu.carry, o_cpu.overflow,
            o_cpu.negative, o_cpu.decimal, o_cpu.unpack} == 6'h00
            && o_cpu.interrupt_mask_flag_low && o_cpu.interrupt_mask_flag_high
            && o_cpu.expand_page_reg == 8'h00
            && o_cpu.first_index_page_reg == 8'h00
            && o_cpu.second_index_page_reg == 8'h00
            && o_cpu.new_code_bank_reg == 8'h01;
    endproperty
    property p_cb;
        $rose(o_cpu_run) |-> o_cpu.code_bank_reg == 8'h01;
    endproperty
    property p_start_cfg;
        $rose(o_cpu_run) |-> o_int_mask && !o_pin_func && o_bus_mode ==
            (i_external_rom_mode ? i_bus_mode_opt : 2'h0);
    endproperty
    property p_mask_gate;
        $fell(o_int_mask) |-> o_cpu_run;
    endproperty
    property p_stab;
        $rose(o_vec_rd) |-> lo_cnt >= (STAB_TICKS - 1) * OSC_DIV
            && lo_cnt <= (STAB_TICKS + 2) * OSC_DIV;
    endproperty
    property p_pulse;
        $fell(o_periph_rst) && !ext_q |-> hi_cnt >= (PULSE_TICKS - 1) * OSC_DIV
            && hi_cnt <= (PULSE_TICKS + 1) * OSC_DIV;
    endproperty

    a_stack_pg: assert property (p_stack_pg) else $error("stack page moved");
    a_hold: assert property (p_hold) else $error("cpu runs in hold");
    a_fetch: assert property (p_fetch) else $error("bad vector fetch");
    a_reg_vals: assert property (p_reg_vals) else $error("bad reset values");
    a_cb: assert property (p_cb) else $error("code bank not loaded");
    a_start_cfg: assert property (p_start_cfg) else $error("bad start cfg");
    a_mask_gate: assert property (p_mask_gate) else $error("mask cleared early");
    a_stab: assert property (p_stab) else $error("wrong stabilise wait");
    a_pulse: assert property (p_pulse) else $error("wrong key pulse");
endmodule

bind irc_initial_reset_controller irc_initial_reset_controller_sva #(
    .OSC_DIV(OSC_DIV),
    .STAB_TICKS(STAB_TICKS),
    .PULSE_TICKS(PULSE_TICKS)
) u_sva (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_reset_pin_b(i_reset_pin_b),
    .i_sleep(i_sleep), .i_external_rom_mode(i_external_rom_mode),
    .i_bus_mode_opt(i_bus_mode_opt), .o_vec_rd(o_vec_rd),
    .o_vec_addr(o_vec_addr), .o_cpu_rst(o_cpu_rst),
    .o_periph_rst(o_periph_rst), .o_cpu_run(o_cpu_run),
    .o_int_mask(o_int_mask), .o_cpu(o_cpu), .o_bus_mode(o_bus_mode),
    .o_pin_func(o_pin_func), .o_stack_page(o_stack_page)
);

`default_nettype wire

// ==== tb/irc_ext_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module irc_ext_model #(
    parameter int POR_CYCLES = 40,
    parameter logic [15:0] START_PC = 16'h1234
) (
    input wire logic i_mclk,
    input wire logic i_pin_req_b,
    input wire logic i_vec_rd,
    input wire logic [23:0] i_vec_addr,
    output logic o_reset_pin_b,
    output logic [7:0] o_vec_data
);
    int por_cnt = 0;
    logic [7:0] idle_q = 8'h5a;

    // Power-up hold of the pin, then the bench's request
    always @(posedge i_mclk) begin
        if (por_cnt < POR_CYCLES) begin
            por_cnt <= por_cnt + 1;
        end
        o_reset_pin_b <= (por_cnt >= POR_CYCLES) && i_pin_req_b;
    end

    // Idle bus toggles so a capture in the wrong cycle shows up
    always @(posedge i_mclk) begin
        idle_q <= ~idle_q;
    end

    // Vector byte stands while the strobe does; captured at its end
    assign o_vec_data = !i_vec_rd ? idle_q :
                        i_vec_addr[0] ? START_PC[15:8] : START_PC[7:0];
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic pin_req_b = 1'b1;
    logic [3:0] keys = 4'hf;
    logic [1:0] key_sel = 2'h0;
    logic sleep = 1'b0;
    logic ext_rom = 1'b0;
    logic [1:0] bus_opt = 2'h2;
    logic cfg_wr = 1'b0;
    logic [23:0] cfg_addr = 24'h000000;
    logic [7:0] cfg_data = 8'h00;
    logic pin_set = 1'b0;
    logic pin_b, vec_rd, cpu_rst, periph_rst, cpu_run, int_mask, pin_func;
    logic [7:0] vec_data, stack_pg;
    logic [23:0] vec_addr;
    logic [1:0] bus_mode;
    irc_pkg::irc_cpu_s cpu;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #10 i_mclk = ~i_mclk;

    irc_initial_reset_controller #(.OSC_DIV(4), .STAB_TICKS(8),
        .QUAL_STEP_TICKS(8), .PULSE_TICKS(4)) uut (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_reset_pin_b(pin_b),
        .i_key_reset_inputs(keys), .i_key_sel(key_sel), .i_sleep(sleep),
        .i_external_rom_mode(ext_rom), .i_bus_mode_opt(bus_opt),
        .i_vec_data(vec_data), .i_cfg_wr(cfg_wr), .i_cfg_addr(cfg_addr),
        .i_cfg_data(cfg_data), .i_pin_func_set(pin_set), .o_vec_rd(vec_rd),
        .o_vec_addr(vec_addr), .o_cpu_rst(cpu_rst), .o_periph_rst(periph_rst),
        .o_cpu_run(cpu_run), .o_int_mask(int_mask), .o_cpu(cpu),
        .o_bus_mode(bus_mode), .o_pin_func(pin_func), .o_stack_page(stack_pg));

    irc_ext_model u_ext (.i_mclk(i_mclk), .i_pin_req_b(pin_req_b),
        .i_vec_rd(vec_rd), .i_vec_addr(vec_addr), .o_reset_pin_b(pin_b),
        .o_vec_data(vec_data));

    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("ERROR %0t delay %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask

    // Wait at falling edges for run (0) or hold (1) to reach a level
    task automatic wait_for(input int sel, input logic v, input int lim,
                            output int n);
        n = 0;
        while (n < lim && (sel == 1 ? periph_rst : cpu_run) !== v) begin
            @(negedge i_mclk);
            n++;
        end
    endtask

    task automatic cfg_write(input logic [23:0] a, input logic [7:0] d);
        cfg_addr = a;
        cfg_data = d;
        cfg_wr = 1'b1;
        @(negedge i_mclk);
        cfg_wr = 1'b0;
    endtask

    // Restart from the pin and check start state
    task automatic pin_reset();
        int n;
        pin_req_b = 1'b0;
        repeat (40) @(negedge i_mclk);
        chk_vec({14'h0, periph_rst, cpu_rst}, 16'h0003);
        cfg_write(24'h00ff00, 8'h00);
        cfg_write(24'h00ff01, 8'h00);
        pin_req_b = 1'b1;
        wait_for(0, 1'b1, 200, n);
        chk_rng(n, 34, 52);
        chk_vec(cpu.pc, 16'h1234);
        chk_vec({8'h00, cpu.code_bank_reg}, 16'h0001);
        chk_vec({15'h0, int_mask}, 16'h0001);
        chk_vec({15'h0, pin_func}, 16'h0000);
        chk_vec({14'h0, bus_mode}, {14'h0, ext_rom ? bus_opt : 2'h0});
    endtask

    // Power-up: held state, then start values
    task automatic t_por();
        int n;
        chk_vec({13'h0, cpu_rst, cpu_run, int_mask}, 16'h0005);
        wait_for(0, 1'b1, 300, n);
        chk_rng(n, 1, 299);
        chk_vec(cpu.pc, 16'h1234);
        chk_vec({8'h00, cpu[63:56]}, 16'h0003);
        chk_vec({8'h00, cpu.expand_page_reg | cpu.first_index_page_reg |
            cpu.second_index_page_reg}, 16'h0000);
        chk_vec({8'h00, cpu.new_code_bank_reg}, 16'h0001);
        chk_vec({8'h00, stack_pg}, 16'h0000);
    endtask

    // Mask release needs both system writes; reset restores defaults
    task automatic t_cfg();
        cfg_write(24'h00ff00, 8'h40);
        @(negedge i_mclk);
        chk_vec({15'h0, int_mask}, 16'h0001);
        chk_vec({14'h0, bus_mode}, 16'h0001);
        cfg_write(24'h00ff01, 8'h00);
        repeat (2) @(negedge i_mclk);
        chk_vec({15'h0, int_mask}, 16'h0000);
        pin_set = 1'b1;
        @(negedge i_mclk);
        pin_set = 1'b0;
        repeat (2) @(negedge i_mclk);
        chk_vec({15'h0, pin_func}, 16'h0001);
        ext_rom = 1'b1;
        pin_reset();
    endtask

    // Option off ignores keys; each group qualifies, pulses and restarts
    task automatic t_keys();
        int n;
        logic [3:0] full;
        keys = 4'h0;
        repeat (150) @(negedge i_mclk);
        chk_vec({15'h0, cpu_run}, 16'h0001);
        keys = 4'hf;
        repeat (10) @(negedge i_mclk);
        for (int s = 1; s < 4; s++) begin
            key_sel = 2'(s);
            full = 4'hf << (s + 1);
            keys = full | 4'h1;
            repeat (120) @(negedge i_mclk);
            chk_vec({15'h0, cpu_run}, 16'h0001);
            keys = full;
            wait_for(1, 1'b1, 200, n);
            chk_rng(n, 36, 80);
            wait_for(0, 1'b1, 200, n);
            chk_rng(n, 40, 64);
            repeat (100) @(negedge i_mclk);
            chk_vec({15'h0, cpu_run}, 16'h0001);
            keys = 4'hf;
            repeat (20) @(negedge i_mclk);
        end
    endtask

    // Deep standby: immediate hold, start after release and wait
    task automatic t_sleep();
        int n;
        sleep = 1'b1;
        keys = 4'h0;
        wait_for(1, 1'b1, 20, n);
        chk_rng(n, 1, 12);
        repeat (100) @(negedge i_mclk);
        chk_vec({15'h0, cpu_run}, 16'h0000);
        keys = 4'hf;
        wait_for(1, 1'b0, 20, n);
        sleep = 1'b0;
        // Keys low again during the stabilisation wait
        keys = 4'h0;
        wait_for(1, 1'b1, 20, n);
        chk_rng(n, 1, 12);
        keys = 4'hf;
        wait_for(1, 1'b0, 20, n);
        wait_for(0, 1'b1, 200, n);
        chk_rng(n, 30, 42);
    endtask

    initial begin
        repeat (12) @(negedge i_mclk);
        i_rst_b = 1'b1;
        t_por();
        t_cfg();
        t_keys();
        t_sleep();
        give_verdict();
    end
endmodule

`default_nettype wire
